// ===== inc/tcx_pkg.sv
// constants for the transceiver channel control block
package tcx_pkg;
  // register byte offsets
  localparam logic [7:0] TCX_CTRL_OFS   = 8'h00;
  localparam logic [7:0] TCX_STAT_OFS   = 8'h04;
  localparam logic [7:0] TCX_ISTAT_OFS  = 8'h08;
  localparam logic [7:0] TCX_IMASK_OFS  = 8'h0C;
  localparam logic [7:0] TCX_THRESH_OFS = 8'h10;
  // control fields
  localparam int TCX_CTRL_PCIE   = 0;
  localparam int TCX_CTRL_NOINF  = 1;
  localparam int TCX_CTRL_REVLB  = 2;
  localparam int TCX_CTRL_BOND   = 4;
  localparam int TCX_BOND_W      = 2;
  // bonding encodings
  localparam logic [1:0] TCX_BOND_NONE = 2'h0;
  localparam logic [1:0] TCX_BOND_X4   = 2'h1;
  localparam logic [1:0] TCX_BOND_X8   = 2'h2;
  // status fields
  localparam int TCX_ST_DATA   = 0;
  localparam int TCX_ST_REFLK  = 1;
  localparam int TCX_ST_SIGDET = 2;
  localparam int TCX_ST_EIDLE  = 3;
  localparam int TCX_ST_FIFOER = 4;
  localparam int TCX_ST_CMUCLK = 5;
  // interrupt event bits
  localparam int TCX_EV_REFLK  = 0;
  localparam int TCX_EV_DATA   = 1;
  localparam int TCX_EV_FIFOER = 2;
  localparam int TCX_EV_SIGCHG = 3;
  localparam int TCX_EV_N      = 4;
  // reset values
  localparam logic [31:0] TCX_CTRL_RST   = 32'h0000_0000;
  localparam logic [7:0]  TCX_THRESH_RST = 8'h04;
  // timing
  localparam int TCX_CLK_PS       = 4000;
  localparam int TCX_REF_LOCK_NS  = 2000;
  localparam int TCX_REF_LOCK_CYC = (TCX_REF_LOCK_NS * 1000 + TCX_CLK_PS - 1) / TCX_CLK_PS;
  localparam int TCX_SD_WIN_CYC   = 64;
  typedef enum logic [1:0] {TCX_REF_ACQ, TCX_REF_LOCK, TCX_DATA_TRK} tcx_cdr_t;
endpackage : tcx_pkg

// ===== rtl/tcx_fifo.sv
// transmit phase compensation fifo with full/empty error flag
`timescale 1ns/1ns
module tcx_fifo
  import tcx_pkg::*;
#(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  input  wire logic         rd_en,
  output logic      [W-1:0] rd_data,
  output logic              fifo_err
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp;
  logic [AW:0]  rp;
  logic         full;
  logic         empty;
  logic         do_wr;
  logic         do_rd;

  assign full  = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign empty = (wp == rp);
  // overflow and underflow are dropped, the flag tells the fabric
  assign do_wr = wr_en && !full;
  assign do_rd = rd_en && !empty;

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wp[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (do_wr) wp <= wp + 1'b1;
      if (do_rd) rp <= rp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data  <= '0;
      fifo_err <= 1'b1;
    end else begin
      if (do_rd) rd_data <= mem[rp[AW-1:0]];
      fifo_err <= full || empty;
    end
  end

  fifo_flag_a: assert property (@(posedge clk) disable iff (rst)
    ##1 fifo_err == $past(full || empty)) else $error("fifo error flag wrong");
endmodule : tcx_fifo

// ===== rtl/tcx_sigdet.sv
// signal detector: counts line transitions over a fixed window
`timescale 1ns/1ns
module tcx_sigdet
  import tcx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       line_bit,
  input  wire logic [7:0] thresh,
  output logic            detect
);
  logic [6:0] win;
  logic [7:0] edges;
  logic       last_bit;
  logic       win_end;

  assign win_end = (win == 7'(TCX_SD_WIN_CYC - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      win      <= '0;
      edges    <= '0;
      last_bit <= 1'b0;
      detect   <= 1'b0;
    end else begin
      last_bit <= line_bit;
      win      <= win_end ? '0 : win + 1'b1;
      if (win_end) begin
        // decision lags by one window; a quiet line drops it after one window
        detect <= (edges >= thresh);
        edges  <= '0;
      end else if (line_bit != last_bit && edges != 8'hFF) begin
        edges <= edges + 1'b1;
      end
    end
  end

  sd_hold_a: assert property (@(posedge clk) disable iff (rst)
    !$past(win_end) |-> $stable(detect)) else $error("detect moved mid window");
endmodule : tcx_sigdet

// ===== rtl/tcx_chan.sv
// transceiver channel: cdr mode control, loopback, signal detect, tx fifo
// Operation
// - force data lock high puts clock recovery in data tracking, ignoring ref lock
// - data/ref lock inputs: 0/0 automatic, 0/1 reference tracking, 1/x data
// - lock mode output high in data tracking, low in reference tracking
// - reference lock output high once recovery has locked to the reference
// - loopback input high enables serial loopback, low disables it
// - signal detect rises only in pcie mode, at or above the programmed threshold
// - with idle inference off in pcie mode, electrical idle is inverted detect
// - fifo error output is high while the tx fifo is full or empty
// - parallel transmit bus width is channel width times channel count
// - non-bonded: each channel's fifo clock is its local divider clock
// - x4 or x8 bonded: multiplier unit clock is the fifo clock
//
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ns
module tcx_chan
  import tcx_pkg::*;
#(
  parameter int CH_W       = 16,
  parameter int N_CH       = 1,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  output logic                        irq,
  input  wire logic                   lock_to_data,
  input  wire logic                   lock_to_ref,
  input  wire logic                   serial_lpbk_en,
  input  wire logic                   rx_serial_in,
  input  wire logic                   rx_lpbk_in,
  input  wire logic                   tx_ser_bit,
  input  wire logic                   tx_rev_lpbk_in,
  output logic                        tx_serial_out,
  output logic                        tx_lpbk_out,
  output logic                        rx_rev_lpbk_out,
  input  wire logic [CH_W*N_CH-1:0]   tx_data,
  input  wire logic                   tx_wr_en,
  input  wire logic                   tx_rd_en,
  output logic      [CH_W*N_CH-1:0]   tx_word,
  output logic                        tx_fifo_err,
  output logic                        freq_locked,
  output logic                        pll_locked,
  output logic                        sig_detect,
  output logic                        elec_idle,
  output logic                        fifo_clk_cmu
);
  logic [31:0]         ctrl;
  logic [7:0]          thresh;
  logic [TCX_EV_N-1:0] istat;
  logic [TCX_EV_N-1:0] imask;
  logic [TCX_EV_N-1:0] ev;
  logic [31:0]         status;
  logic                wr_acc;
  logic                rd_acc;
  logic                pcie_mode;
  logic                no_infer;
  logic                rev_lpbk;
  logic [1:0]          bond;
  logic                rx_bit;
  logic                sd_raw;
  logic                sd_prev;
  logic                err_prev;
  logic                data_prev;
  logic                lk_prev;
  logic [31:0]         rd_mux;
  tcx_cdr_t            cdr;
  tcx_cdr_t            next_cdr;
  logic [$clog2(TCX_REF_LOCK_CYC+1)-1:0] ref_cnt;
  logic                ref_done;

  function automatic logic [31:0] byte_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  sel
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = new_v[8*i +: 8];
    end
    return r;
  endfunction : byte_merge

  assign pcie_mode = ctrl[TCX_CTRL_PCIE];
  assign no_infer  = ctrl[TCX_CTRL_NOINF];
  assign rev_lpbk  = ctrl[TCX_CTRL_REVLB];
  assign bond      = ctrl[TCX_CTRL_BOND +: TCX_BOND_W];

  // wishbone slave, one wait state, every address answers
  assign wr_acc = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
  assign rd_acc = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl   <= TCX_CTRL_RST;
      thresh <= TCX_THRESH_RST;
      imask  <= '0;
    end else if (wr_acc) begin
      case (wb_adr_i)
        TCX_CTRL_OFS:   ctrl   <= byte_merge(ctrl, wb_dat_i, wb_sel_i);
        TCX_IMASK_OFS:  if (wb_sel_i[0]) imask <= wb_dat_i[TCX_EV_N-1:0];
        TCX_THRESH_OFS: if (wb_sel_i[0]) thresh <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    status = '0;
    status[TCX_ST_DATA]   = freq_locked;
    status[TCX_ST_REFLK]  = pll_locked;
    status[TCX_ST_SIGDET] = sig_detect;
    status[TCX_ST_EIDLE]  = elec_idle;
    status[TCX_ST_FIFOER] = tx_fifo_err;
    status[TCX_ST_CMUCLK] = fifo_clk_cmu;
    case (wb_adr_i)
      TCX_CTRL_OFS:   rd_mux = ctrl;
      TCX_STAT_OFS:   rd_mux = status;
      TCX_ISTAT_OFS:  rd_mux = {28'h0000000, istat};
      TCX_IMASK_OFS:  rd_mux = {28'h0000000, imask};
      TCX_THRESH_OFS: rd_mux = {24'h000000, thresh};
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_dat_o <= '0;
    end else if (rd_acc) begin
      wb_dat_o <= rd_mux;
    end
  end

  // serial loopback selects the looped transmit stream into the receiver
  assign rx_bit = serial_lpbk_en ? rx_lpbk_in : rx_serial_in;

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_lpbk_out     <= 1'b0;
      rx_rev_lpbk_out <= 1'b0;
      tx_serial_out   <= 1'b0;
    end else begin
      tx_lpbk_out     <= serial_lpbk_en ? tx_ser_bit : 1'b0;
      rx_rev_lpbk_out <= rev_lpbk ? rx_serial_in : 1'b0;
      tx_serial_out   <= rev_lpbk ? tx_rev_lpbk_in : tx_ser_bit;
    end
  end

  tcx_sigdet u_sd (
    .clk      (clk),
    .rst      (rst),
    .line_bit (rx_bit),
    .thresh   (thresh),
    .detect   (sd_raw)
  );

  // clock recovery mode machine
  assign ref_done = (ref_cnt == TCX_REF_LOCK_CYC[$bits(ref_cnt)-1:0]);

  always_comb begin
    next_cdr = cdr;
    case (cdr)
      TCX_REF_ACQ:  if (ref_done) next_cdr = TCX_REF_LOCK;
      TCX_REF_LOCK: if (!lock_to_ref && sd_raw) next_cdr = TCX_DATA_TRK;
      TCX_DATA_TRK: if (!sd_raw || lock_to_ref) next_cdr = TCX_REF_ACQ;
      default:      next_cdr = TCX_REF_ACQ;
    endcase
    if (lock_to_data) next_cdr = TCX_DATA_TRK;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cdr <= TCX_REF_ACQ;
    end else begin
      cdr <= next_cdr;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || cdr != TCX_REF_ACQ) begin
      ref_cnt <= '0;
    end else if (!ref_done) begin
      ref_cnt <= ref_cnt + 1'b1;
    end
  end

  // indicators are registered; fabric still treats them as asynchronous
  always_ff @(posedge clk) begin
    if (rst) begin
      freq_locked  <= 1'b0;
      pll_locked   <= 1'b0;
      sig_detect   <= 1'b0;
      elec_idle    <= 1'b0;
      fifo_clk_cmu <= 1'b0;
    end else begin
      freq_locked  <= (next_cdr == TCX_DATA_TRK);
      pll_locked   <= (next_cdr == TCX_REF_LOCK);
      sig_detect   <= pcie_mode && sd_raw;
      elec_idle    <= pcie_mode && no_infer && !sd_raw;
      // clock source of the phase compensation fifo
      fifo_clk_cmu <= (bond == TCX_BOND_X4) || (bond == TCX_BOND_X8);
    end
  end

  tcx_fifo #(
    .W     (CH_W * N_CH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .wr_en    (tx_wr_en),
    .wr_data  (tx_data),
    .rd_en    (tx_rd_en),
    .rd_data  (tx_word),
    .fifo_err (tx_fifo_err)
  );

  // interrupt events on edges of state
  always_ff @(posedge clk) begin
    if (rst) begin
      sd_prev   <= 1'b0;
      err_prev  <= 1'b1;
      data_prev <= 1'b0;
      lk_prev   <= 1'b0;
    end else begin
      sd_prev   <= sig_detect;
      err_prev  <= tx_fifo_err;
      data_prev <= freq_locked;
      lk_prev   <= pll_locked;
    end
  end

  always_comb begin
    ev = '0;
    ev[TCX_EV_REFLK]  = pll_locked && !lk_prev;
    ev[TCX_EV_DATA]   = freq_locked && !data_prev;
    ev[TCX_EV_FIFOER] = tx_fifo_err && !err_prev;
    ev[TCX_EV_SIGCHG] = sig_detect != sd_prev;
  end

  // set beats the write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      istat <= '0;
    end else if (wr_acc && wb_adr_i == TCX_ISTAT_OFS && wb_sel_i[0]) begin
      istat <= (istat & ~wb_dat_i[TCX_EV_N-1:0]) | ev;
    end else begin
      istat <= istat | ev;
    end
  end

  assign irq = |(istat & imask);

  force_data_a: assert property (@(posedge clk) disable iff (rst)
    lock_to_data |=> freq_locked && !pll_locked) else $error("force data lock ignored");

  ref_mode_a: assert property (@(posedge clk) disable iff (rst)
    !lock_to_data && lock_to_ref |=> !freq_locked) else $error("ref mode left");

  mode_ind_a: assert property (@(posedge clk) disable iff (rst)
    freq_locked |-> !pll_locked) else $error("mode indicator conflict");

  ref_lock_a: assert property (@(posedge clk) disable iff (rst)
    $rose(pll_locked) |-> !$past(lock_to_data)) else $error("ref lock while forced");

  lpbk_sel_a: assert property (@(posedge clk) disable iff (rst)
    !serial_lpbk_en |=> !tx_lpbk_out) else $error("loopback out while disabled");

  sd_gate_a: assert property (@(posedge clk) disable iff (rst)
    !pcie_mode |=> !sig_detect) else $error("detect outside pcie");

  eidle_inv_a: assert property (@(posedge clk) disable iff (rst)
    pcie_mode && no_infer |=> elec_idle == !sig_detect) else $error("idle not inverse");

  clk_src_a: assert property (@(posedge clk) disable iff (rst)
    bond == TCX_BOND_NONE |=> !fifo_clk_cmu) else $error("bonded clock when unbonded");

  wb_ack_a: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
endmodule : tcx_chan

// ===== sim/tcx_fab.sv
// fabric-side model: line stimulus and indicator synchronisers
`timescale 1ns/1ns
module tcx_fab
  import tcx_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic line_act,
  input  wire logic pll_locked,
  input  wire logic freq_locked,
  output logic      line_bit,
  output logic      pll_sync,
  output logic      freq_sync
);
  logic [1:0] s_pll;
  logic [1:0] s_frq;
  // idle line sits low, as if pulled down; active line toggles each cycle
  always_ff @(posedge clk) begin
    if (rst || !line_act)
      line_bit <= 1'b0;
    else
      line_bit <= ~line_bit;
  end
  // indicators are asynchronous, so two stages before any use
  always_ff @(posedge clk) begin
    s_pll <= {s_pll[0], pll_locked};
    s_frq <= {s_frq[0], freq_locked};
  end
  assign pll_sync  = s_pll[1];
  assign freq_sync = s_frq[1];
endmodule : tcx_fab

// ===== sim/tb.sv
// self-checking testbench for the transceiver channel block
`timescale 1ns/1ns
module tb;
  import tcx_pkg::*;
  logic        clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        lock_to_data, lock_to_ref, serial_lpbk_en, tx_ser_bit;
  logic        tx_serial_out, tx_lpbk_out, rx_rev_lpbk_out, line_act, line_bit;
  logic [15:0] tx_data, tx_word;
  logic        tx_wr_en, tx_rd_en, tx_fifo_err, freq_locked, pll_locked;
  logic        sig_detect, elec_idle, fifo_clk_cmu, pll_sync, freq_sync;
  int          err_count, samples_checked, cycles;

  // loopback ports wired across as an integrator would
  tcx_chan u_dut (
    .clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .lock_to_data, .lock_to_ref,
    .serial_lpbk_en, .rx_serial_in(line_bit), .rx_lpbk_in(tx_lpbk_out),
    .tx_ser_bit, .tx_rev_lpbk_in(rx_rev_lpbk_out),
    .tx_serial_out, .tx_lpbk_out, .rx_rev_lpbk_out, .tx_data, .tx_wr_en,
    .tx_rd_en, .tx_word, .tx_fifo_err, .freq_locked, .pll_locked,
    .sig_detect, .elec_idle, .fifo_clk_cmu
  );
  tcx_fab u_fab (
    .clk, .rst, .line_act, .pll_locked, .freq_locked, .line_bit, .pll_sync,
    .freq_sync
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // hang guard, the whole run needs under 3000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      tally_and_finish;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task step(input int k);
    repeat (k) @(posedge clk);
  endtask : step

  // one classic cycle; entered just after an edge
  // no local limit: a slave that never answers is caught by the hang guard
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask : wb

  task wait_det(input logic v);
    int n;
    n = 0;
    while (sig_detect !== v && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk(sig_detect, v);
  endtask : wait_det

  task t_reset;
    chk(tx_fifo_err, 1'b1);
    wb(1'b0, TCX_THRESH_OFS, 32'h0);
    chk(rd, 32'(TCX_THRESH_RST));
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, TCX_CTRL_OFS, 32'h0);
    chk(rd, TCX_CTRL_RST);
    $display("reset test done");
  endtask : t_reset

  // fill past full, then drain in order
  task t_fifo;
    for (int i = 0; i < 9; i++) begin
      tx_data  <= 16'h00A0 + 16'(i);
      // writes share the channel clock, so zero frequency offset
      tx_wr_en <= 1'b1;
      @(posedge clk);
      if (i == 4)
        chk(tx_fifo_err, 1'b0);
    end
    tx_wr_en <= 1'b0;
    step(2);
    chk(tx_fifo_err, 1'b1);
    for (int i = 0; i < 9; i++) begin
      tx_rd_en <= (i < 8);
      @(posedge clk);
      if (i > 0)
        chk(tx_word, 16'h00A0 + 16'(i - 1));
    end
    step(2);
    chk(tx_fifo_err, 1'b1);
    $display("fifo test done");
  endtask : t_fifo

  task t_loop;
    logic [1:0] h;
    serial_lpbk_en <= 1'b1;
    tx_ser_bit     <= 1'b1;
    step(3);
    chk(tx_lpbk_out, 1'b1);
    tx_ser_bit <= 1'b0;
    step(3);
    chk(tx_lpbk_out, 1'b0);
    tx_ser_bit     <= 1'b1;
    serial_lpbk_en <= 1'b0;
    step(3);
    chk(tx_lpbk_out, 1'b0);
    chk(tx_serial_out, 1'b1);
    wb(1'b1, TCX_CTRL_OFS, 32'h1 << TCX_CTRL_REVLB);
    line_act <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      if (i > 1) begin
        chk(tx_serial_out, h[1]);
        chk(rx_rev_lpbk_out, h[0]);
      end
      h = {h[0], line_bit};
    end
    line_act <= 1'b0;
    wb(1'b1, TCX_CTRL_OFS, 32'h0);
    $display("loopback test done");
  endtask : t_loop

  task t_bond;
    logic [1:0] b;
    for (int i = 0; i < 3; i++) begin
      b = (i == 0) ? TCX_BOND_X4 : (i == 1) ? TCX_BOND_X8 : TCX_BOND_NONE;
      wb(1'b1, TCX_CTRL_OFS, 32'(b) << TCX_CTRL_BOND);
      step(2);
      chk(fifo_clk_cmu, i < 2);
    end
    $display("bonding test done");
  endtask : t_bond

  // detect with idle inference off, plus the change interrupt
  task t_sig;
    wb(1'b1, TCX_ISTAT_OFS, 32'hF);
    wb(1'b1, TCX_IMASK_OFS, 32'h1 << TCX_EV_SIGCHG);
    wb(1'b1, TCX_CTRL_OFS, 32'h3);
    line_act <= 1'b1;
    wait_det(1'b1);
    step(2);
    chk(elec_idle, 1'b0);
    chk(irq, 1'b1);
    wb(1'b1, TCX_ISTAT_OFS, 32'h1 << TCX_EV_SIGCHG);
    step(2);
    chk(irq, 1'b0);
    line_act <= 1'b0;
    wait_det(1'b0);
    step(2);
    chk(elec_idle, 1'b1);
    wb(1'b1, TCX_IMASK_OFS, 32'h0);
    step(2);
    chk(irq, 1'b0);
    wb(1'b0, TCX_ISTAT_OFS, 32'h0);
    chk(rd[TCX_EV_SIGCHG], 1'b1);
    wb(1'b1, TCX_CTRL_OFS, 32'h0);
    line_act <= 1'b1;
    step(200);
    chk(sig_detect, 1'b0);
    line_act <= 1'b0;
    $display("signal detect test done");
  endtask : t_sig

  task t_cdr;
    int n;
    lock_to_ref <= 1'b1;
    rst         <= 1'b1;
    step(4);
    rst <= 1'b0;
    n = 0;
    while (pll_sync !== 1'b1 && n < 700) begin
      @(posedge clk);
      n++;
    end
    chk(n >= TCX_REF_LOCK_CYC && n <= TCX_REF_LOCK_CYC + 8, 1'b1);
    chk(freq_locked, 1'b0);
    wb(1'b0, TCX_ISTAT_OFS, 32'h0);
    chk(rd[TCX_EV_REFLK], 1'b1);
    lock_to_data <= 1'b1;
    step(2);
    chk(freq_locked, 1'b1);
    lock_to_ref <= 1'b0;
    step(2);
    chk(freq_locked, 1'b1);
    chk(freq_sync, 1'b1);
    lock_to_data <= 1'b0;
    step(3);
    chk(freq_locked, 1'b0);
    $display("clock recovery test done");
  endtask : t_cdr

  initial begin
    rst            = 1'b1;
    wb_cyc_i       = 1'b0;
    wb_stb_i       = 1'b0;
    wb_we_i        = 1'b0;
    wb_adr_i       = 8'h00;
    wb_sel_i       = 4'hF;
    wb_dat_i       = 32'h0;
    lock_to_data   = 1'b0;
    lock_to_ref    = 1'b0;
    serial_lpbk_en = 1'b0;
    tx_ser_bit     = 1'b0;
    tx_data        = 16'h0;
    tx_wr_en       = 1'b0;
    tx_rd_en       = 1'b0;
    line_act       = 1'b0;
    step(4);
    rst <= 1'b0;
    t_reset;
    t_fifo;
    t_loop;
    t_bond;
    t_sig;
    t_cdr;
    tally_and_finish;
  end
endmodule : tb
